// File: hdl/rmlc_pkg.sv
package rmlc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_GEN_CNT = 12'h008;
  localparam logic [11:0] ADDR_RESULT  = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h014;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_DIAG_BIT    = 0;
  localparam int CTRL_EXPERT_BIT  = 1;
  localparam int CTRL_MODE_LSB    = 2;
  localparam int CTRL_INTERP_BIT  = 4;
  localparam int CTRL_CLEAR_BIT   = 5;
  localparam int CTRL_ENTER_BIT   = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt event bits
  localparam int EV_START    = 0;
  localparam int EV_DONE     = 1;
  localparam int EV_OVERSPD  = 2;
  localparam int EV_BITS     = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int HOLD_MS       = 500;
  localparam int HOLD_CYCLES   = CLK_HZ / 1000 * HOLD_MS;
  localparam int MIN_EDGE_GAP  = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RMLC_OP_COUNT   = 2'b00,
    RMLC_OP_LINES   = 2'b01,
    RMLC_OP_BAR     = 2'b10,
    RMLC_OP_SUPPLY  = 2'b11
  } rmlc_op_t;

  typedef enum logic [1:0] {
    RMLC_WAIT   = 2'b00,
    RMLC_COUNT  = 2'b01,
    RMLC_HOLD   = 2'b10,
    RMLC_IDLE   = 2'b11
  } rmlc_meas_t;

  typedef struct packed {
    logic a;
    logic b;
    logic ref_mark;
  } rmlc_enc_t;

  typedef struct packed {
    logic step;
    logic up;
  } rmlc_step_t;

endpackage : rmlc_pkg

// File: hdl/rmlc_quad.sv
// Quadrature decoder: single or four-fold evaluation
module rmlc_quad (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Encoder and control
  input  wire rmlc_pkg::rmlc_enc_t enc,
  input  wire logic               fourfold,
  // Decoded step
  output rmlc_pkg::rmlc_step_t    step,
  output logic                    rm_rise
);

  typedef struct packed {
    logic [1:0] ab;
    logic       rm;
    rmlc_pkg::rmlc_step_t st;
    logic       rmr;
  } rmlc_quad_t;

  rmlc_quad_t s_reg;
  rmlc_quad_t s_next;

  // Direction from phase relation of A and B
  always_comb begin
    logic [1:0] cur;
    cur = {enc.a, enc.b};
    s_next = s_reg;
    s_next.ab = cur;
    s_next.rm = enc.ref_mark;
    s_next.rmr = enc.ref_mark & ~s_reg.rm;
    s_next.st.step = 1'b0;
    s_next.st.up = s_reg.st.up;
    if (cur != s_reg.ab) begin
      // A leads B counts up
      s_next.st.up = (s_reg.ab[0] ^ cur[1]);
      // Single-fold: only rising A edges count
      s_next.st.step = fourfold ? 1'b1 : (cur[1] & ~s_reg.ab[1]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign step    = s_reg.st;
  assign rm_rise = s_reg.rmr;

endmodule : rmlc_quad

// File: hdl/rmlc_apb.sv
// APB slave register front end
module rmlc_apb (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [11:0] acc_addr,
  output logic      [31:0] acc_wdata,
  input  wire logic [31:0] rd_value,
  input  wire logic        rd_valid
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
    logic        rdy;
  } rmlc_apb_t;

  rmlc_apb_t s_reg;
  rmlc_apb_t s_next;

  // Zero wait state: ready and error are raised from the setup cycle,
  // so both stand in the first access cycle straight from flip-flops
  assign wr_stb    = psel & penable & pwrite;
  assign rd_stb    = psel & penable & ~pwrite;
  assign acc_addr  = paddr;
  assign acc_wdata = pwdata;

  always_comb begin
    s_next = s_reg;
    if (psel && !penable && !pwrite) begin
      s_next.rdata = rd_valid ? rd_value : 32'h0000_0000;
    end
    s_next.err = 1'b0;
    s_next.rdy = 1'b0;
    if (psel && !penable) begin
      s_next.err = ~rd_valid;
      s_next.rdy = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata  = s_reg.rdata;
  assign pready  = s_reg.rdy;
  assign pslverr = s_reg.err;

endmodule : rmlc_apb

// File: hdl/rmlc_core.sv
// Register access over APB and the address map are this design's own decisions.
module rmlc_core #(
  parameter int CNT_W       = 32,
  parameter int HOLD_CYCLES = rmlc_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Encoder
  input  wire rmlc_pkg::rmlc_enc_t enc,
  // Outputs
  output logic                     sense_connect,
  output logic                     overspeed_error,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]          ctrl;
    logic [CNT_W-1:0]     gen_cnt;
    logic [CNT_W-1:0]     meas_cnt;
    logic [CNT_W-1:0]     result;
    logic                 valid;
    rmlc_pkg::rmlc_meas_t meas;
    logic [31:0]          hold_cnt;
    logic [3:0]           gap_cnt;
    logic                 ovs;
    logic [rmlc_pkg::EV_BITS-1:0] ist;
    logic [rmlc_pkg::EV_BITS-1:0] imsk;
    logic                 sense;
    logic                 irq;
  } rmlc_core_t;

  rmlc_core_t s_reg;
  rmlc_core_t s_next;

  logic                 wr_stb;
  logic                 rd_stb;
  logic [11:0]          acc_addr;
  logic [31:0]          acc_wdata;
  logic [31:0]          rd_value;
  logic                 rd_valid;
  rmlc_pkg::rmlc_step_t st;
  logic                 rm_rise;
  rmlc_pkg::rmlc_op_t   op;
  logic                 fourfold;

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic up);
    bump = up ? v + CNT_W'(1) : v - CNT_W'(1);
  endfunction : bump

  // Any write to the control register, which may change mode or enter
  function automatic logic ctrl_write(input logic stb, input logic [11:0] addr);
    ctrl_write = stb && addr == rmlc_pkg::ADDR_CTRL;
  endfunction : ctrl_write

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  rmlc_apb rmlc_apb_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .acc_addr  (acc_addr),
    .acc_wdata (acc_wdata),
    .rd_value  (rd_value),
    .rd_valid  (rd_valid)
  );

  // Line measurement forces single-fold evaluation
  assign op       = rmlc_pkg::rmlc_op_t'(s_reg.ctrl[rmlc_pkg::CTRL_MODE_LSB +: 2]);
  assign fourfold = s_reg.ctrl[rmlc_pkg::CTRL_INTERP_BIT] && (op == rmlc_pkg::RMLC_OP_COUNT);

  rmlc_quad rmlc_quad_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .enc      (enc),
    .fourfold (fourfold),
    .step     (st),
    .rm_rise  (rm_rise)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_valid = 1'b1;
    unique case (acc_addr)
      rmlc_pkg::ADDR_CTRL:    rd_value = s_reg.ctrl;
      rmlc_pkg::ADDR_STATUS:  rd_value = {27'h0, s_reg.sense, s_reg.ovs,
                                          s_reg.valid, s_reg.meas};
      rmlc_pkg::ADDR_GEN_CNT: rd_value = 32'(s_reg.gen_cnt);
      rmlc_pkg::ADDR_RESULT:  rd_value = 32'(s_reg.result);
      rmlc_pkg::ADDR_IRQ_ST:  rd_value = {29'h0, s_reg.ist};
      rmlc_pkg::ADDR_IRQ_MSK: rd_value = {29'h0, s_reg.imsk};
      default:                rd_valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                         clr_req;
    logic                         enter;
    logic                         too_fast;
    logic [rmlc_pkg::EV_BITS-1:0] ev;
    clr_req  = 1'b0;
    enter    = 1'b0;
    too_fast = 1'b0;
    ev       = '0;
    s_next   = s_reg;

    // Register writes; clear and enter bits are self-clearing strobes
    s_next.ctrl[rmlc_pkg::CTRL_CLEAR_BIT] = 1'b0;
    s_next.ctrl[rmlc_pkg::CTRL_ENTER_BIT] = 1'b0;
    if (wr_stb) begin
      unique case (acc_addr)
        rmlc_pkg::ADDR_CTRL: begin
          s_next.ctrl = {25'h0, acc_wdata[6:0]};
          clr_req = acc_wdata[rmlc_pkg::CTRL_CLEAR_BIT];
          enter   = acc_wdata[rmlc_pkg::CTRL_ENTER_BIT] ||
                    (acc_wdata[3:2] == rmlc_pkg::RMLC_OP_LINES && op != rmlc_pkg::RMLC_OP_LINES);
        end
        rmlc_pkg::ADDR_IRQ_MSK: s_next.imsk = acc_wdata[rmlc_pkg::EV_BITS-1:0];
        default: ;
      endcase
    end

    // General counter, counts every decoded step
    if (st.step) begin
      s_next.gen_cnt = bump(s_reg.gen_cnt, st.up);
    end
    // Clear only with diagnostic and extended access both on
    if (clr_req && s_reg.ctrl[rmlc_pkg::CTRL_DIAG_BIT] && s_reg.ctrl[rmlc_pkg::CTRL_EXPERT_BIT]) begin
      s_next.gen_cnt = '0;
    end

    // Overspeed: two edges closer than the scan limit
    if (st.step) begin
      too_fast = (s_reg.gap_cnt < 4'(rmlc_pkg::MIN_EDGE_GAP));
      s_next.gap_cnt = 4'h0;
    end else if (s_reg.gap_cnt != 4'hf) begin
      s_next.gap_cnt = s_reg.gap_cnt + 4'h1;
    end

    // Measurement sequence; entry first, so a switch out of bar mode
    // into line measurement is never lost to the bar branch
    if (enter) begin
      // Clear on entry
      s_next.meas_cnt = '0;
      s_next.meas     = rmlc_pkg::RMLC_WAIT;
      s_next.ovs      = 1'b0;
      s_next.valid    = 1'b0;
    end else if (op == rmlc_pkg::RMLC_OP_BAR) begin
      // Every mark zeroes and restarts, no hold
      s_next.meas = rmlc_pkg::RMLC_COUNT;
      if (rm_rise) begin
        s_next.meas_cnt = '0;
      end else if (st.step) begin
        s_next.meas_cnt = bump(s_reg.meas_cnt, st.up);
      end
      s_next.result = s_next.meas_cnt;
    end else begin
      unique case (s_reg.meas)
        rmlc_pkg::RMLC_WAIT: begin
          // Idle until first mark
          if (rm_rise) begin
            s_next.meas  = rmlc_pkg::RMLC_COUNT;
            s_next.valid = 1'b0;
            s_next.ovs   = 1'b0;
            ev[rmlc_pkg::EV_START] = 1'b1;
          end
        end
        rmlc_pkg::RMLC_COUNT: begin
          if (rm_rise) begin
            // Stop and publish
            s_next.result   = s_reg.meas_cnt;
            s_next.valid    = ~s_reg.ovs & ~too_fast;
            s_next.meas     = rmlc_pkg::RMLC_HOLD;
            s_next.hold_cnt = '0;
            ev[rmlc_pkg::EV_DONE] = 1'b1;
          end else if (st.step) begin
            s_next.meas_cnt = bump(s_reg.meas_cnt, st.up);
          end
        end
        rmlc_pkg::RMLC_HOLD: begin
          // Frozen; marks ignored until hold time passes
          if (s_reg.hold_cnt >= 32'(HOLD_CYCLES - 1)) begin
            s_next.meas = rmlc_pkg::RMLC_IDLE;
          end else begin
            s_next.hold_cnt = s_reg.hold_cnt + 32'h1;
          end
        end
        rmlc_pkg::RMLC_IDLE: begin
          // Next mark ends the break; restart with a clear
          if (rm_rise) begin
            s_next.meas_cnt = '0;
            s_next.meas     = rmlc_pkg::RMLC_WAIT;
          end
        end
      endcase
    end

    // Overspeed set last: it wins over a clear by entry or start mark
    if (too_fast) begin
      s_next.ovs   = 1'b1;
      s_next.valid = 1'b0;
      ev[rmlc_pkg::EV_OVERSPD] = 1'b1;
    end

    // Supply path opened only in supply-monitor mode
    s_next.sense = (rmlc_pkg::rmlc_op_t'(s_next.ctrl[3:2]) != rmlc_pkg::RMLC_OP_SUPPLY);

    // Sticky events; a read clears only what it reported, so an event
    // between setup and access survives, and a new set wins
    if (rd_stb && acc_addr == rmlc_pkg::ADDR_IRQ_ST) begin
      s_next.ist = (s_reg.ist & ~prdata[rmlc_pkg::EV_BITS-1:0]) | ev;
    end else begin
      s_next.ist = s_reg.ist | ev;
    end
    s_next.irq = |(s_next.ist & s_next.imsk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.ctrl  <= rmlc_pkg::CTRL_RESET;
      s_reg.sense <= 1'b1;
      s_reg.gap_cnt <= 4'hf; // No false overspeed on the first step
    end else begin
      s_reg <= s_next;
    end
  end

  assign sense_connect   = s_reg.sense;
  assign overspeed_error = s_reg.ovs;
  assign irq             = s_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_supply_sense: assert property (@(posedge pclk) disable iff (!presetn)
    (op == rmlc_pkg::RMLC_OP_SUPPLY) |-> !sense_connect)
    else $error("sense path not opened in supply mode");

  a_clear_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.gen_cnt != '0 && !st.step &&
     !(s_reg.ctrl[rmlc_pkg::CTRL_DIAG_BIT] && s_reg.ctrl[rmlc_pkg::CTRL_EXPERT_BIT]))
    |=> s_reg.gen_cnt == $past(s_reg.gen_cnt))
    else $error("general counter cleared without access");

  a_entry_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stb && acc_addr == rmlc_pkg::ADDR_CTRL && acc_wdata[rmlc_pkg::CTRL_ENTER_BIT]
     && acc_wdata[3:2] != rmlc_pkg::RMLC_OP_BAR)
    |=> s_reg.meas_cnt == '0 && s_reg.meas == rmlc_pkg::RMLC_WAIT)
    else $error("entry did not clear measurement");

  a_wait_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.meas == rmlc_pkg::RMLC_WAIT && op != rmlc_pkg::RMLC_OP_BAR)
    |=> s_reg.meas_cnt == $past(s_reg.meas_cnt))
    else $error("counter moved while waiting");

  a_stop_result: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.meas == rmlc_pkg::RMLC_COUNT && rm_rise && !ctrl_write(wr_stb, acc_addr) &&
     op != rmlc_pkg::RMLC_OP_BAR)
    |=> s_reg.result == $past(s_reg.meas_cnt) && s_reg.meas == rmlc_pkg::RMLC_HOLD)
    else $error("stop mark did not publish result");

  a_hold_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.meas == rmlc_pkg::RMLC_HOLD && !ctrl_write(wr_stb, acc_addr) &&
     op != rmlc_pkg::RMLC_OP_BAR)
    |=> s_reg.result == $past(s_reg.result) && s_reg.meas != rmlc_pkg::RMLC_COUNT)
    else $error("result changed during hold");

  a_bar_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (op == rmlc_pkg::RMLC_OP_BAR && rm_rise && !wr_stb) |=> s_reg.result == '0)
    else $error("bar mode mark did not zero");

  a_overspeed_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (st.step && s_reg.gap_cnt < 4'(rmlc_pkg::MIN_EDGE_GAP))
    |=> overspeed_error && !s_reg.valid)
    else $error("overspeed not flagged");

  a_gen_step: assert property (@(posedge pclk) disable iff (!presetn)
    (st.step && !ctrl_write(wr_stb, acc_addr))
    |=> s_reg.gen_cnt == bump($past(s_reg.gen_cnt), $past(st.up)))
    else $error("general counter missed a step");

  a_hold_length: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.meas == rmlc_pkg::RMLC_HOLD && s_reg.hold_cnt < 32'(HOLD_CYCLES - 1) &&
     !ctrl_write(wr_stb, acc_addr) && op != rmlc_pkg::RMLC_OP_BAR)
    |=> s_reg.meas == rmlc_pkg::RMLC_HOLD)
    else $error("hold ended early");

  // Steps of the measurement cycle, shared by the checks below
  sequence s_wait_mark;
    s_reg.meas == rmlc_pkg::RMLC_WAIT && rm_rise && !ctrl_write(wr_stb, acc_addr) &&
    op != rmlc_pkg::RMLC_OP_BAR;
  endsequence : s_wait_mark

  sequence s_idle_mark;
    s_reg.meas == rmlc_pkg::RMLC_IDLE && rm_rise && !ctrl_write(wr_stb, acc_addr) &&
    op != rmlc_pkg::RMLC_OP_BAR;
  endsequence : s_idle_mark

  sequence s_fresh_wait;
    s_reg.meas == rmlc_pkg::RMLC_WAIT && s_reg.meas_cnt == '0;
  endsequence : s_fresh_wait

  a_start_count: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_mark |=> s_reg.meas == rmlc_pkg::RMLC_COUNT)
    else $error("first mark did not start count");

  a_restart_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle_mark |=> s_fresh_wait)
    else $error("idle mark did not restart with clear");

endmodule : rmlc_core

// File: verif/rmlc_enc.sv
// Encoder under test: quadrature lines and reference mark, levels on pclk
module rmlc_enc (
  // Clock
  input  wire logic           pclk,
  // Encoder lines
  output rmlc_pkg::rmlc_enc_t enc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] ph;

  // Lines rest at phase zero
  initial begin
    enc = '0;
    ph  = 2'd0;
  end

  // Gray walk 00,10,11,01: A leads B moving up; five cycles per edge
  // keeps four-fold steps clear of the overspeed gap
  task automatic move(input int edges, input logic up);
    for (int i = 0; i < edges; i++) begin
      repeat (5) @(posedge pclk);
      ph = up ? ph + 2'd1 : ph - 2'd1;
      enc.a <= ph[1] ^ ph[0];
      enc.b <= ph[1];
    end
    repeat (4) @(posedge pclk);
  endtask : move

  // Noisy A line: rising edges two cycles apart, A ends where it began
  task automatic chatter(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge pclk);
      enc.a <= ~enc.a;
    end
    repeat (4) @(posedge pclk);
  endtask : chatter

  // Reference mark pulse, two cycles wide
  task automatic mark();
    @(posedge pclk);
    enc.ref_mark <= 1'b1;
    repeat (2) @(posedge pclk);
    enc.ref_mark <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : mark
endmodule : rmlc_enc

// File: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Constants and signals
  // ----------------------------------------------------------------
  localparam int          HOLD_SIM = 60;
  localparam logic [11:0] A_CT     = rmlc_pkg::ADDR_CTRL;
  localparam logic [11:0] A_ST     = rmlc_pkg::ADDR_STATUS;
  localparam logic [11:0] A_GC     = rmlc_pkg::ADDR_GEN_CNT;
  localparam logic [11:0] A_RS     = rmlc_pkg::ADDR_RESULT;
  localparam logic [11:0] A_IS     = rmlc_pkg::ADDR_IRQ_ST;
  localparam logic [11:0] A_IM     = rmlc_pkg::ADDR_IRQ_MSK;
  localparam logic [31:0] DI       = 32'h1 << rmlc_pkg::CTRL_DIAG_BIT;
  localparam logic [31:0] DG       = DI | (32'h1 << rmlc_pkg::CTRL_EXPERT_BIT);
  localparam logic [31:0] FF       = 32'h1 << rmlc_pkg::CTRL_INTERP_BIT;
  localparam logic [31:0] CLR      = 32'h1 << rmlc_pkg::CTRL_CLEAR_BIT;
  localparam logic [31:0] ENT      = 32'h1 << rmlc_pkg::CTRL_ENTER_BIT;
  localparam logic [31:0] S_W      = {30'h0, rmlc_pkg::RMLC_WAIT};
  localparam logic [31:0] S_C      = {30'h0, rmlc_pkg::RMLC_COUNT};
  localparam logic [31:0] S_H      = {30'h0, rmlc_pkg::RMLC_HOLD};
  localparam logic [31:0] S_I      = {30'h0, rmlc_pkg::RMLC_IDLE};
  localparam logic [31:0] SM       = 32'h3;
  localparam logic [31:0] VM       = 32'h4;
  localparam logic [31:0] OM       = 32'h8;
  localparam logic [31:0] CM       = 32'h10;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rq, base;
  logic                sense_connect, overspeed_error, irq, re;
  rmlc_pkg::rmlc_enc_t enc;
  int                  err_total = 0;
  int                  checks_done = 0;
  int                  cyc = 0;

  rmlc_core #(.CNT_W(32), .HOLD_CYCLES(HOLD_SIM)) rmlc_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc(enc),
    .sense_connect(sense_connect), .overspeed_error(overspeed_error), .irq(irq)
  );

  rmlc_enc rmlc_enc_inst (.pclk(pclk), .enc(enc));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard, far above the roughly 800 cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic chk1(input string nm, input logic e, input logic g);
    check(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(nm, e & m, rq & m);
  endtask : rchk

  function automatic logic [31:0] md(input logic [1:0] m);
    return {30'h0, m} << rmlc_pkg::CTRL_MODE_LSB;
  endfunction : md

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk1("sense_connect", 1'b1, sense_connect);
    chk1("overspeed_error", 1'b0, overspeed_error);
    chk1("irq", 1'b0, irq);
    rchk("ctrl", A_CT, rmlc_pkg::CTRL_RESET, '1);
    rchk("irq_mask", A_IM, 32'h0, '1);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, re});
    check("unmapped_data", 32'h0, rq);
  endtask : t_reset

  task automatic t_count();
    apb(1'b0, A_GC, 32'h0);
    base = rq;
    rmlc_enc_inst.move(8, 1'b1);
    rchk("gen_single_up", A_GC, base + 32'd2, '1);
    wr(A_CT, FF);
    rmlc_enc_inst.move(12, 1'b0);
    rchk("gen_four_down", A_GC, base - 32'd10, '1);
    base = base - 32'd10;
  endtask : t_count

  // Clear refused without both access bits already set
  task automatic t_clear();
    wr(A_CT, FF | CLR);
    rchk("gen_clr_refused", A_GC, base, '1);
    wr(A_CT, FF | DI);
    wr(A_CT, FF | DI | CLR);
    rchk("gen_clr_no_expert", A_GC, base, '1);
    wr(A_CT, DG);
    wr(A_CT, DG | CLR);
    rchk("gen_cleared", A_GC, 32'h0, '1);
    rchk("ctrl_strobe_low", A_CT, DG, '1);
  endtask : t_clear

  // Four-fold asked for on entry; single-fold must win
  task automatic t_lines();
    wr(A_IM, 32'h1 << rmlc_pkg::EV_DONE);
    wr(A_CT, FF | md(2'd1));
    rmlc_enc_inst.move(4, 1'b1);
    rchk("wait_state", A_ST, S_W, SM);
    rmlc_enc_inst.mark();
    rchk("count_state", A_ST, S_C, SM);
    rmlc_enc_inst.move(20, 1'b1);
    chk1("irq_masked", 1'b0, irq);
    rmlc_enc_inst.mark();
    chk1("irq_done", 1'b1, irq);
    rchk("hold_state", A_ST, S_H | VM, SM | VM);
    rchk("result_single", A_RS, 32'd5, '1);
    rmlc_enc_inst.mark();
    rmlc_enc_inst.move(4, 1'b1);
    rchk("hold_ignores", A_ST, S_H, SM);
    rchk("result_frozen", A_RS, 32'd5, '1);
    rchk("irq_status", A_IS, 32'h3, 32'h7);
    repeat (2) @(posedge pclk);
    chk1("irq_cleared", 1'b0, irq);
    repeat (HOLD_SIM) @(posedge pclk);
    rchk("idle_state", A_ST, S_I, SM);
    rmlc_enc_inst.mark();
    rchk("rewait_state", A_ST, S_W, SM);
    rmlc_enc_inst.move(8, 1'b1);
    rmlc_enc_inst.mark();
    rmlc_enc_inst.move(16, 1'b0);
    rmlc_enc_inst.mark();
    rchk("result_neg", A_RS, 32'h0 - 32'd4, '1);
  endtask : t_lines

  task automatic t_over();
    wr(A_IM, 32'h1 << rmlc_pkg::EV_OVERSPD);
    wr(A_CT, md(2'd1) | ENT);
    rmlc_enc_inst.mark();
    rmlc_enc_inst.chatter(4);
    chk1("overspeed_pin", 1'b1, overspeed_error);
    chk1("irq_overspeed", 1'b1, irq);
    rmlc_enc_inst.mark();
    rchk("stop_invalid", A_ST, S_H | OM, SM | VM | OM);
    rchk("irq_st_ovs", A_IS, 32'h4, 32'h4);
    wr(A_CT, md(2'd1) | ENT);
    repeat (2) @(posedge pclk);
    chk1("overspeed_clr", 1'b0, overspeed_error);
  endtask : t_over

  // Marks back to back, no hold between them
  task automatic t_bar();
    wr(A_CT, md(2'd2));
    rmlc_enc_inst.mark();
    rmlc_enc_inst.move(12, 1'b1);
    rchk("bar_running", A_RS, 32'd3, '1);
    rmlc_enc_inst.mark();
    rchk("bar_zeroed", A_RS, 32'd0, '1);
    rmlc_enc_inst.move(8, 1'b1);
    rchk("bar_no_hold", A_RS, 32'd2, '1);
  endtask : t_bar

  task automatic t_supply();
    wr(A_CT, md(2'd3));
    repeat (2) @(posedge pclk);
    chk1("sense_open", 1'b0, sense_connect);
    rchk("status_sense", A_ST, 32'h0, CM);
    wr(A_CT, md(2'd0));
    repeat (2) @(posedge pclk);
    chk1("sense_closed", 1'b1, sense_connect);
  endtask : t_supply

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Main sequence after 16 cycles of reset
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_clear();
    t_lines();
    t_over();
    t_bar();
    t_supply();
    conclude();
  end
endmodule : tb_top
